// [logic/touch_qual_pkg.sv]
// constants for the touch detection qualifier: register map, field layout,
// reset values and gesture codes; shared by the qualifier module and its testbench.
package touch_qual_pkg;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_THRESH = 8'h04;
	localparam logic [7:0] REG_GRIP = 8'h08;
	localparam logic [7:0] REG_PALM = 8'h0c;
	localparam logic [7:0] REG_GEST = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_OBJ_BASE = 8'h40;
	localparam int CTRL_GRIP_EN = 0;
	localparam int CTRL_PALM_EN = 1;
	localparam int CTRL_GEST1_EN = 2;
	localparam int CTRL_GEST2_EN = 3;
	localparam int CTRL_HOP_EN = 4;
	localparam int CTRL_W = 5;
	localparam int OBJ_LIM_LSB = 0;
	localparam int OBJ_GRP_LSB = 4;
	localparam int OBJ_IEN_BIT = 12;
	localparam int OBJ_KEY_BIT = 13;
	localparam int OBJ_ARR_LSB = 14;
	localparam int PALM_DIST_LSB = 8;
	localparam int GEST_PINCH_LSB = 16;
	localparam int STATUS_REP_LSB = 16;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [15:0] THRESH_RST = 16'h0020;
	localparam logic [9:0] BORDER_RST = 10'h000;
	localparam logic [7:0] PALM_SIZE_RST = 8'h40;
	localparam logic [10:0] PALM_DIST_RST = 11'h040;
	localparam logic [10:0] DRAG_RST = 11'h010;
	localparam logic [10:0] PINCH_RST = 11'h010;
	localparam logic [15:0] OBJ_RST = 16'h0003;
	typedef enum logic [1:0] {GEST_NONE, GEST_TAP, GEST_DRAG, GEST_PINCH} gesture_t;
endpackage : touch_qual_pkg

// [logic/touch_detect_qualifier.sv]
// touch detection qualifier: per-object integration, group lockout, grip and
// palm rejection, delta hop filter and simple gestures, over classic Wishbone.
// assumes acquisition data comes from logic on clk_i, one acq_valid_i pulse per frame.
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module touch_detect_qualifier import touch_qual_pkg::*; #(
	parameter int N = 4,
	parameter logic [9:0] X_MAX = 10'h3ff,
	parameter logic [9:0] Y_MAX = 10'h3ff
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	input wire logic we_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic acq_valid_i,
	input wire logic [N*16-1:0] delta_i,
	input wire logic [N*10-1:0] pos_x_i,
	input wire logic [N*10-1:0] pos_y_i,
	input wire logic [N*8-1:0] size_i,
	output logic [N-1:0] touch_o,
	output logic report_valid_o,
	output gesture_t gesture_o,
	output logic gesture_valid_o
);
	localparam int IW = $clog2(N);

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [CTRL_W-1:0] ctrl;
		logic [15:0] thr;
		logic [9:0] border;
		logic [7:0] palm_size;
		logic [10:0] palm_dist;
		logic [10:0] drag_thr;
		logic [10:0] pinch_thr;
		logic [N-1:0][15:0] cfg;
		logic [N-1:0][15:0] prev;
		logic [N-1:0][3:0] cnt;
		logic [N-1:0] det;
		logic [N-1:0] touch;
		logic rep_v;
		gesture_t gest;
		logic gest_v;
		logic g1_act;
		logic g1_moved;
		logic [IW-1:0] g1_idx;
		logic [9:0] g1_x;
		logic [9:0] g1_y;
		logic g2_act;
		logic [10:0] g2_dist;
	} state_t;

	state_t s_q, s_d;
	logic [N-1:0][15:0] filt;
	logic [N-1:0] above, reach, palm, grip, rep;
	logic [N-1:0] det_n;
	logic [7:0] off;
	logic [IW-1:0] ridx;

	function automatic logic [10:0] absd(input logic [10:0] a, input logic [10:0] b);
		absd = (a > b) ? a - b : b - a;
	endfunction : absd

	function automatic logic [10:0] mdist(input logic [9:0] xa, input logic [9:0] ya,
			input logic [9:0] xb, input logic [9:0] yb);
		mdist = absd({1'b0, xa}, {1'b0, xb}) + absd({1'b0, ya}, {1'b0, yb});
	endfunction : mdist

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		for (int b = 0; b < 4; b++)
			merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
	endfunction : merge

	assign off = {adr_i[7:2], 2'b00};
	assign ridx = IW'(adr_i[7:2] - REG_OBJ_BASE[7:2]);

	always_comb begin
		int c;
		int a;
		int b;
		logic [31:0] w;
		logic [3:0] lim;
		logic [10:0] d;
		logic blk;
		c = 0;
		a = 0;
		b = 0;
		w = 32'h0000_0000;
		lim = 4'h0;
		d = 11'h000;
		blk = 1'b0;
		s_d = s_q;
		s_d.rep_v = 1'b0;
		s_d.gest_v = 1'b0;
		// one wait state; ack drops the cycle after it was given
		s_d.ack = cyc_i & stb_i & ~s_q.ack;
		s_d.rdat = 32'h0000_0000;
		if (off == REG_CTRL) begin
			s_d.rdat = 32'(s_q.ctrl);
		end else if (off == REG_THRESH) begin
			s_d.rdat = 32'(s_q.thr);
		end else if (off == REG_GRIP) begin
			s_d.rdat = 32'(s_q.border);
		end else if (off == REG_PALM) begin
			s_d.rdat = 32'({s_q.palm_dist, s_q.palm_size});
		end else if (off == REG_GEST) begin
			s_d.rdat = {5'h00, s_q.pinch_thr, 5'h00, s_q.drag_thr};
		end else if (off == REG_STATUS) begin
			s_d.rdat = (32'(s_q.touch) << STATUS_REP_LSB) | 32'(s_q.det);
		end else if (off >= REG_OBJ_BASE && 32'(adr_i[7:2] - REG_OBJ_BASE[7:2]) < N) begin
			s_d.rdat = 32'(s_q.cfg[ridx]);
		end
		if (s_d.ack && we_i) begin
			w = merge(s_d.rdat, dat_i, sel_i);
			if (off == REG_CTRL) begin
				s_d.ctrl = w[CTRL_W-1:0];
			end else if (off == REG_THRESH) begin
				s_d.thr = w[15:0];
			end else if (off == REG_GRIP) begin
				s_d.border = w[9:0];
			end else if (off == REG_PALM) begin
				s_d.palm_size = w[7:0];
				s_d.palm_dist = w[PALM_DIST_LSB +: 11];
			end else if (off == REG_GEST) begin
				s_d.drag_thr = w[10:0];
				s_d.pinch_thr = w[GEST_PINCH_LSB +: 11];
			end else if (off >= REG_OBJ_BASE && 32'(adr_i[7:2] - REG_OBJ_BASE[7:2]) < N) begin
				s_d.cfg[ridx] = w[15:0];
			end
		end
		// per-object qualification; evaluated every cycle, committed on acq_valid_i
		det_n = s_q.det;
		for (int i = 0; i < N; i++) begin
			w[16:0] = {delta_i[i*16+15], delta_i[i*16 +: 16]} + {s_q.prev[i][15], s_q.prev[i]};
			filt[i] = s_q.ctrl[CTRL_HOP_EN] ? w[16:1] : delta_i[i*16 +: 16];
			above[i] = $signed(filt[i]) > $signed(s_q.thr);
			lim = s_q.cfg[i][OBJ_LIM_LSB +: 4];
			lim = (lim == 4'h0) ? 4'h1 : lim;
			reach[i] = above[i] && ({1'b0, s_q.cnt[i]} + 5'h01 >= {1'b0, lim});
			if (!above[i])
				det_n[i] = 1'b0; // release; keeps a held touch until here
		end
		// ascending scan: a lower index wins a tie in the same frame
		for (int i = 0; i < N; i++) begin
			blk = 1'b0;
			for (int j = 0; j < N; j++) begin
				if (j != i && det_n[j]) begin
					if ((s_q.cfg[i][OBJ_GRP_LSB +: 8] & s_q.cfg[j][OBJ_GRP_LSB +: 8]) != 8'h00)
						blk = 1'b1;
					if (s_q.cfg[i][OBJ_IEN_BIT] && s_q.cfg[i][OBJ_KEY_BIT] && s_q.cfg[j][OBJ_KEY_BIT]
							&& s_q.cfg[i][OBJ_ARR_LSB +: 2] == s_q.cfg[j][OBJ_ARR_LSB +: 2])
						blk = 1'b1;
				end
			end
			if (!s_q.det[i] && reach[i] && !blk)
				det_n[i] = 1'b1;
		end
		for (int i = 0; i < N; i++) begin
			palm[i] = s_q.ctrl[CTRL_PALM_EN] && !s_q.cfg[i][OBJ_KEY_BIT]
				&& det_n[i] && size_i[i*8 +: 8] > s_q.palm_size;
			grip[i] = s_q.ctrl[CTRL_GRIP_EN] && !s_q.cfg[i][OBJ_KEY_BIT] && (
				pos_x_i[i*10 +: 10] < s_q.border || pos_x_i[i*10 +: 10] > X_MAX - s_q.border ||
				pos_y_i[i*10 +: 10] < s_q.border || pos_y_i[i*10 +: 10] > Y_MAX - s_q.border);
		end
		for (int i = 0; i < N; i++) begin
			rep[i] = det_n[i] && !palm[i] && !grip[i];
			for (int j = 0; j < N; j++) begin
				if (j != i && palm[j] && !s_q.cfg[i][OBJ_KEY_BIT] && mdist(pos_x_i[i*10 +: 10],
						pos_y_i[i*10 +: 10], pos_x_i[j*10 +: 10], pos_y_i[j*10 +: 10]) <= s_q.palm_dist)
					rep[i] = 1'b0;
			end
		end
		if (acq_valid_i) begin
			for (int i = 0; i < N; i++) begin
				s_d.prev[i] = delta_i[i*16 +: 16];
				lim = s_q.cfg[i][OBJ_LIM_LSB +: 4];
				if (!above[i])
					s_d.cnt[i] = 4'h0;
				else if (reach[i])
					s_d.cnt[i] = (lim == 4'h0) ? 4'h1 : lim;
				else
					s_d.cnt[i] = s_q.cnt[i] + 4'h1;
				if (rep[i]) begin
					if (c == 0)
						a = i;
					else if (c == 1)
						b = i;
					c = c + 1;
				end
			end
			s_d.det = det_n;
			s_d.touch = rep;
			s_d.rep_v = 1'b1;
			// one-touch processor starts only when exactly one object is reported, then follows that object
			if (s_q.ctrl[CTRL_GEST1_EN]) begin
				if (s_q.g1_act) begin
					if (!rep[s_q.g1_idx]) begin
						s_d.g1_act = 1'b0;
						if (!s_q.g1_moved) begin
							s_d.gest = GEST_TAP;
							s_d.gest_v = 1'b1;
						end
					end else if (mdist(pos_x_i[32'(s_q.g1_idx)*10 +: 10], pos_y_i[32'(s_q.g1_idx)*10 +: 10],
							s_q.g1_x, s_q.g1_y) > s_q.drag_thr) begin
						s_d.g1_moved = 1'b1;
						s_d.gest = GEST_DRAG;
						s_d.gest_v = 1'b1;
					end
				end else if (c == 1) begin
					s_d.g1_act = 1'b1;
					s_d.g1_moved = 1'b0;
					s_d.g1_idx = IW'(a);
					s_d.g1_x = pos_x_i[a*10 +: 10];
					s_d.g1_y = pos_y_i[a*10 +: 10];
				end
			end else begin
				s_d.g1_act = 1'b0;
			end
			// two-touch processor: spread change beyond the pinch step
			if (s_q.ctrl[CTRL_GEST2_EN] && c == 2) begin
				d = mdist(pos_x_i[a*10 +: 10], pos_y_i[a*10 +: 10], pos_x_i[b*10 +: 10], pos_y_i[b*10 +: 10]);
				if (s_q.g2_act && absd(d, s_q.g2_dist) > s_q.pinch_thr) begin
					s_d.gest = GEST_PINCH;
					s_d.gest_v = 1'b1;
				end
				s_d.g2_act = 1'b1;
				s_d.g2_dist = d;
			end else begin
				s_d.g2_act = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RST;
			s_q.thr <= THRESH_RST;
			s_q.border <= BORDER_RST;
			s_q.palm_size <= PALM_SIZE_RST;
			s_q.palm_dist <= PALM_DIST_RST;
			s_q.drag_thr <= DRAG_RST;
			s_q.pinch_thr <= PINCH_RST;
			s_q.cfg <= {N{OBJ_RST}};
			s_q.gest <= GEST_NONE;
		end else begin
			s_q <= s_d;
		end
	end

	assign dat_o = s_q.rdat;
	assign ack_o = s_q.ack;
	assign touch_o = s_q.touch;
	assign report_valid_o = s_q.rep_v;
	assign gesture_o = s_q.gest;
	assign gesture_valid_o = s_q.gest_v;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_wb_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	chk_wb_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing one cycle after request");
	chk_integ_count: assert property (acq_valid_i && above[0] && !reach[0]
			|=> s_q.cnt[0] == $past(s_q.cnt[0]) + 4'h1)
		else $error("counter did not step by one");
	chk_integ_limit: assert property (acq_valid_i && !s_q.det[0] && !reach[0] |=> !s_q.det[0])
		else $error("detect declared before limit");
	chk_integ_clear: assert property (acq_valid_i && !above[0] |=> s_q.cnt[0] == 4'h0 && !s_q.det[0])
		else $error("counter not cleared below threshold");
	chk_hold_detect: assert property (acq_valid_i && s_q.det[0] && above[0] |=> s_q.det[0])
		else $error("held touch dropped while above threshold");
	chk_group_block: assert property (acq_valid_i && s_q.det[0] && above[0] && !s_q.det[1]
			&& (s_q.cfg[0][OBJ_GRP_LSB +: 8] & s_q.cfg[1][OBJ_GRP_LSB +: 8]) != 8'h00 |=> !s_q.det[1])
		else $error("group member entered detect while locked");
	chk_grip_reject: assert property (acq_valid_i && grip[0] |=> !touch_o[0] && report_valid_o)
		else $error("touch reported inside grip border");
	chk_palm_reject: assert property (acq_valid_i && palm[0] |=> !touch_o[0])
		else $error("palm-sized touch reported");
	chk_hop_filter: assert property (acq_valid_i |=> s_q.prev[0] == $past(delta_i[15:0]))
		else $error("hop filter history not taken from delta");
endmodule : touch_detect_qualifier

`default_nettype wire

// [test/acq_model.sv]
// acquisition engine model: delivers one frame of per-object data per call
// assumes frame() is called from a process that runs on clk_i
`timescale 1ns/10ps
`default_nettype none
module acq_model #(
	parameter int N = 4
) (
	input wire logic clk_i,
	output logic acq_valid_o,
	output logic [N*16-1:0] delta_o,
	output logic [N*10-1:0] pos_x_o,
	output logic [N*10-1:0] pos_y_o,
	output logic [N*8-1:0] size_o
);
	initial begin
		acq_valid_o = 1'b0;
		delta_o = '0;
		pos_x_o = '0;
		pos_y_o = '0;
		size_o = '0;
	end
	// outside a frame the data is inverted so stale values cannot pass for valid ones
	task automatic frame(input logic [N*16-1:0] d, input logic [N*10-1:0] x, input logic [N*8-1:0] s, input int gap);
		@(posedge clk_i);
		acq_valid_o <= 1'b1;
		delta_o <= d;
		pos_x_o <= x;
		pos_y_o <= {N{10'h200}};
		size_o <= s;
		@(posedge clk_i);
		acq_valid_o <= 1'b0;
		delta_o <= ~d;
		pos_x_o <= ~x;
		pos_y_o <= ~{N{10'h200}};
		size_o <= ~s;
		repeat (gap) @(posedge clk_i);
	endtask : frame
endmodule : acq_model
`default_nettype wire

// [test/test_touch_detect_qualifier.sv]
// self-checking bench: wishbone register access plus frames from acq_model
// assumes N=4 and the package register map; expectations queued, checked on outputs
`timescale 1ns/10ps
`default_nettype none
module test_touch_detect_qualifier import touch_qual_pkg::*;;
	localparam logic [39:0] DX = {10'h280, 10'h200, 10'h180, 10'h100};
	localparam logic [31:0] DS = {4{8'h08}};
	logic clk_i, rst_i, we_i, cyc_i, stb_i, acq_valid, ack_o, report_valid_o, gesture_valid_o;
	logic [7:0] adr_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0] sel_i, touch_o;
	logic [63:0] delta, rd_d;
	logic [39:0] pos_x, pos_y;
	logic [31:0] size;
	logic [3:0] rex;
	gesture_t gesture_o;
	int failures, comparisons, cycles;
	logic [31:0] rd_q[$];
	logic [3:0] tq_q[$];
	gesture_t gq_q[$];
	gesture_t ge;
	int gc, ga, gb, gi, gd, pd;
	logic g1a, g2a;
	touch_detect_qualifier #(.N(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.acq_valid_i(acq_valid), .delta_i(delta), .pos_x_i(pos_x), .pos_y_i(pos_y), .size_i(size),
		.touch_o(touch_o), .report_valid_o(report_valid_o), .gesture_o(gesture_o),
		.gesture_valid_o(gesture_valid_o));
	acq_model #(.N(4)) u_acq (.clk_i(clk_i), .acq_valid_o(acq_valid), .delta_o(delta), .pos_x_o(pos_x),
		.pos_y_o(pos_y), .size_o(size));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	// the monitor owns the queued dat_o, touch_o and gesture_o comparisons; only the reset touch_o and final queue checks run in the driver
	always @(posedge clk_i) begin
		cycles++;
		if (ack_o === 1'b1 && we_i === 1'b0) chk("dat_o", rd_q.pop_front(), dat_o);
		if (report_valid_o === 1'b1) chk("touch_o", {28'h0, tq_q.pop_front()}, {28'h0, touch_o});
		if (gesture_valid_o === 1'b1) chk("gesture_o", 32'(gq_q.pop_front()), 32'(gesture_o));
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		// no local limit: only the bench timeout ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		wb(1'b0, a, 32'h0, 4'hf);
	endtask : rd
	task automatic objs(input logic [15:0] v0, v1, v2, v3);
		wb(1'b1, REG_OBJ_BASE, {16'h0, v0}, 4'hf);
		wb(1'b1, REG_OBJ_BASE + 8'h04, {16'h0, v1}, 4'hf);
		wb(1'b1, REG_OBJ_BASE + 8'h08, {16'h0, v2}, 4'hf);
		wb(1'b1, REG_OBJ_BASE + 8'h0c, {16'h0, v3}, 4'hf);
	endtask : objs
	task automatic fr(input logic [63:0] d, input logic [39:0] x, input logic [31:0] s, input logic [3:0] e);
		tq_q.push_back(e);
		u_acq.frame(d, x, s, int'($urandom_range(0, 2)));
	endtask : fr
	task automatic fs(input logic [3:0] on, input logic [3:0] e);
		logic [63:0] d;
		for (int i = 0; i < 4; i++) d[16*i+:16] = on[i] ? 16'h0100 : 16'h0000;
		fr(d, DX, DS, e);
	endtask : fs
	initial begin
		{we_i, cyc_i, stb_i, adr_i, dat_i, sel_i} = '0;
		failures = 0;
		comparisons = 0;
		cycles = 0;
		rst_i = 1'b1;
		void'($urandom(26));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("touch_o", 32'h0, {28'h0, touch_o});
		rd(REG_CTRL, 32'h0);
		rd(REG_THRESH, 32'(THRESH_RST));
		rd(REG_PALM, 32'(PALM_SIZE_RST) | (32'(PALM_DIST_RST) << PALM_DIST_LSB));
		rd(REG_GEST, 32'(DRAG_RST) | (32'(PINCH_RST) << GEST_PINCH_LSB));
		rd(REG_OBJ_BASE, 32'(OBJ_RST));
		rd(8'h3c, 32'h0);
		wb(1'b1, REG_STATUS, 32'hffffffff, 4'hf);
		rd(REG_STATUS, 32'h0);
		wb(1'b1, REG_OBJ_BASE + 8'h0c, 32'hffffff05, 4'h1);
		rd(REG_OBJ_BASE + 8'h0c, 32'h5);
		$display("done: registers");
		fs(4'h1, 4'h0);
		fs(4'h1, 4'h0);
		fs(4'h1, 4'h1);
		fs(4'h0, 4'h0);
		fs(4'h1, 4'h0);
		fs(4'h0, 4'h0);
		fs(4'h1, 4'h0);
		fs(4'h1, 4'h0);
		fs(4'h1, 4'h1);
		fs(4'h0, 4'h0);
		$display("done: integration");
		objs(16'h0011, 16'h2011, 16'h0031, 16'h0021);
		fs(4'h2, 4'h2);
		fs(4'h3, 4'h2);
		fs(4'h1, 4'h1);
		fs(4'h3, 4'h1);
		fs(4'h0, 4'h0);
		fs(4'h8, 4'h8);
		fs(4'hc, 4'h8);
		fs(4'hd, 4'h9);
		fs(4'h0, 4'h0);
		objs(16'h2001, 16'h2001, 16'h0001, 16'h0001);
		fs(4'h3, 4'h3);
		objs(16'h3001, 16'h3001, 16'h0001, 16'h0001);
		fs(4'h3, 4'h3);
		fs(4'h1, 4'h1);
		fs(4'h3, 4'h1);
		fs(4'h0, 4'h0);
		objs(16'h0012, 16'h0012, 16'h0001, 16'h0001);
		fs(4'h3, 4'h0);
		fs(4'h3, 4'h1);
		fs(4'h0, 4'h0);
		$display("done: lockout");
		objs(16'h0001, 16'h0001, 16'h0001, 16'h0001);
		wb(1'b1, REG_CTRL, 32'h1, 4'hf);
		wb(1'b1, REG_GRIP, 32'h10, 4'hf);
		fr({16'h0, {3{16'h0100}}}, {10'h280, 10'h200, 10'h3f8, 10'h005}, DS, 4'h4);
		rd(REG_STATUS, 32'h0004_0007);
		fs(4'h0, 4'h0);
		wb(1'b1, REG_CTRL, 32'h2, 4'hf);
		fr({16'h0, {3{16'h0100}}}, {10'h280, 10'h200, 10'h120, 10'h100}, 32'h08400880, 4'h4);
		fs(4'h0, 4'h0);
		wb(1'b1, REG_CTRL, 32'h10, 4'hf);
		fs(4'h1, 4'h1);
		fs(4'h0, 4'h1);
		fs(4'h0, 4'h0);
		$display("done: grip palm hop");
		wb(1'b1, REG_CTRL, 32'h04, 4'hf);
		fs(4'h1, 4'h1);
		gq_q.push_back(GEST_TAP);
		fs(4'h0, 4'h0);
		fs(4'h1, 4'h1);
		gq_q.push_back(GEST_DRAG);
		fr({48'h0, 16'h0100}, {10'h280, 10'h200, 10'h180, 10'h140}, DS, 4'h1);
		fs(4'h0, 4'h0);
		wb(1'b1, REG_CTRL, 32'h08, 4'hf);
		fs(4'h3, 4'h3);
		gq_q.push_back(GEST_PINCH);
		fs(4'h5, 4'h5);
		fs(4'h0, 4'h0);
		$display("done: gestures");
		wb(1'b1, REG_CTRL, 32'h0c, 4'hf);
		// reference gesture state: positions are fixed, so only taps and pinches can occur
		g1a = 1'b0;
		g2a = 1'b0;
		repeat (16) begin
			for (int i = 0; i < 4; i++) begin
				rd_d[16*i+:16] = 16'($urandom) & 16'h003f;
				rex[i] = rd_d[16*i+:16] > 16'h0020;
			end
			ge = GEST_NONE;
			gc = 0;
			for (int i = 3; i >= 0; i--) begin
				if (rex[i]) begin
					gb = ga;
					ga = i;
					gc++;
				end
			end
			if (g1a && !rex[gi]) begin
				g1a = 1'b0;
				ge = GEST_TAP;
			end else if (!g1a && gc == 1) begin
				g1a = 1'b1;
				gi = ga;
			end
			if (gc == 2) begin
				gd = 128 * (gb - ga);
				if (g2a && (gd - pd > 16 || pd - gd > 16)) ge = GEST_PINCH;
				g2a = 1'b1;
				pd = gd;
			end else begin
				g2a = 1'b0;
			end
			if (ge != GEST_NONE) gq_q.push_back(ge);
			fr(rd_d, DX, DS, rex);
		end
		$display("done: random frames");
		repeat (5) @(posedge clk_i);
		chk("queues", 32'h0, 32'(rd_q.size() + tq_q.size() + gq_q.size()));
		complete_run();
	end
endmodule : test_touch_detect_qualifier
`default_nettype wire
